//--- design/brw_pkg.sv
// Package: constants for the button reset, watchdog and interrupt block
package brw_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int CLK_PERIOD_NS = 10;
  // Interrupt pulse width
  localparam int INT_PULSE_US = 128;
  localparam int INT_PULSE_CYC = (INT_PULSE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Adapter watchdog window
  localparam int WDOG_S = 14;
  localparam longint WDOG_CYC_L = longint'(WDOG_S) * longint'(CLK_HZ);
  localparam int WDOG_CYC = int'(WDOG_CYC_L);
  // Default long-press and warning times in milliseconds
  localparam int LPRESS_MS_DEF = 10000;
  localparam int WARN_LEAD_MS_DEF = 1000;
  localparam int MS_CYC = CLK_HZ / 1000;
  // Power-cycle off time of the system rail
  localparam int PCYC_OFF_MS = 100;
  localparam int PCYC_OFF_CYC = PCYC_OFF_MS * MS_CYC;
  // Long-press action encoding
  localparam logic [1:0] ACT_HARDWARE_RESET_REQUEST = 2'h0;
  localparam logic [1:0] ACT_NONE = 2'h1;
  localparam int ACT_SHIP_BIT = 1;
  localparam int CNT_W = 32;
  localparam int NUM_SRC = 5;
  localparam int SRC_RESET_WARN = 0;
  localparam int SRC_CV = 1;
  localparam int SRC_CHG_DONE = 2;
  localparam int SRC_FAULT = 3;
  localparam int SRC_STATUS = 4;
endpackage

//--- design/brw_edge_irq.sv
// Masked rising-edge interrupt source detector
module brw_edge_irq (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic cond_in,
  input wire logic mask_in,
  output logic event_out
);
  logic cond_q;
  wire new_rise = cond_in & ~cond_q;
  // Mask only gates new edges, so unmasking during a held condition stays silent
  assign event_out = new_rise & ~mask_in;
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) cond_q <= 1'b0;
    else cond_q <= cond_in;
  end
endmodule

//--- design/brw_pulse_gen.sv
// Fixed-width active low pulse generator for the open-drain interrupt pin
module brw_pulse_gen #(
  parameter int WIDTH_CYC = brw_pkg::INT_PULSE_CYC
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic trig_in,
  output logic drive_low_out
);
  import brw_pkg::*;
  initial begin
    if (WIDTH_CYC < 8) $error("pulse width must be at least eight cycles");
  end
  logic [CNT_W-1:0] cnt;
  // Triggers during a running pulse are merged into it; the host reads flags for detail
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) cnt <= '0;
    else if (trig_in && cnt == '0) cnt <= CNT_W'(WIDTH_CYC);
    else if (cnt != '0) cnt <= cnt - 1'b1;
  end
  assign drive_low_out = (cnt != '0);
  property p_pulse_width;
    @(posedge sys_clk_in) disable iff (rst_in)
      (trig_in && cnt == '0) |=> drive_low_out [*8];
  endproperty
  a_pulse_width: assert property (p_pulse_width) else $error("interrupt pulse too short");
endmodule

//--- design/brw_top.sv
// Top: long-press decode, adapter watchdog, power cycle and interrupt pin
module brw_top #(
  parameter int WDOG_CYCLES = brw_pkg::WDOG_CYC,
  parameter int LPRESS_CYCLES_DEF = brw_pkg::LPRESS_MS_DEF * brw_pkg::MS_CYC,
  parameter int WARN_LEAD_CYCLES = brw_pkg::WARN_LEAD_MS_DEF * brw_pkg::MS_CYC,
  parameter int PCYC_OFF_CYCLES = brw_pkg::PCYC_OFF_CYC,
  parameter int INT_CYCLES = brw_pkg::INT_PULSE_CYC
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic button_input_n_in,
  input wire logic [1:0] long_press_action_in,
  input wire logic long_press_action_wr_in,
  input wire logic [31:0] long_press_cycles_in,
  input wire logic reset_requires_input_power_in,
  input wire logic input_power_valid_in,
  input wire logic adapter_connect_in,
  input wire logic hardware_reset_request_in,
  input wire logic adapter_watchdog_enable_in,
  input wire logic i2c_transaction_in,
  input wire logic startup_valid_in,
  input wire logic startup_fault_in,
  input wire logic cv_regulation_in,
  input wire logic charge_done_in,
  input wire logic fault_in,
  input wire logic status_change_in,
  input wire logic [brw_pkg::NUM_SRC-1:0] int_mask_in,
  input wire logic flags_read_in,
  output logic reset_warning_flag_out,
  output logic cv_status_flag_out,
  output logic [1:0] long_press_action_out,
  output logic system_output_rail_en_out,
  output logic digital_io_rail_en_out,
  output logic ship_mode_out,
  output logic hardware_reset_request_active_out,
  output logic int_n_out,
  output logic int_oe_out
);
  import brw_pkg::*;
  initial begin
    if (WDOG_CYCLES < 1 || PCYC_OFF_CYCLES < 1 || INT_CYCLES < 1) $error("counts must be positive");
    if (WARN_LEAD_CYCLES >= LPRESS_CYCLES_DEF) $error("warning lead must be shorter than long press");
  end

  typedef enum logic [1:0] {BRW_RUN, BRW_OFF, BRW_SHIP} brw_pwr_e;
  brw_pwr_e pwr, next_pwr;

  // Button synchroniser: first stage read only by the second
  logic btn_s1, btn_s2, btn_low_q;
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      btn_s1 <= 1'b1;
      btn_s2 <= 1'b1;
      btn_low_q <= 1'b0;
    end else begin
      btn_s1 <= button_input_n_in;
      btn_s2 <= btn_s1;
      btn_low_q <= ~btn_s2;
    end
  end
  wire btn_low = ~btn_s2;
  wire press_start = btn_low & ~btn_low_q;

  // Action register written by host; per-press copy latched at press start, then follows writes that are not blocked
  logic [1:0] action;
  logic [1:0] press_action;
  logic pressing;
  wire wr_to_reset = (long_press_action_in == ACT_HARDWARE_RESET_REQUEST) && (press_action != ACT_HARDWARE_RESET_REQUEST);
  wire wr_block = pressing && wr_to_reset;
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) action <= ACT_NONE;
    else if (long_press_action_wr_in && !wr_block) action <= long_press_action_in;
  end
  assign long_press_action_out = action;
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) press_action <= ACT_NONE;
    else if (press_start) press_action <= action;
    else if (pressing && long_press_action_wr_in && !wr_block) press_action <= long_press_action_in;
  end

  // Long-press timer; duration is latched at press start so rewrites wait
  logic [CNT_W-1:0] lp_cnt, lp_len;
  logic lp_done, vin_ok_press;
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) lp_len <= CNT_W'(LPRESS_CYCLES_DEF);
    else if (!pressing && !press_start && long_press_cycles_in > CNT_W'(WARN_LEAD_CYCLES))
      lp_len <= long_press_cycles_in;
  end
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      pressing <= 1'b0;
      lp_cnt <= '0;
      lp_done <= 1'b0;
    end else if (!btn_low) begin
      pressing <= 1'b0;
      lp_cnt <= '0;
      lp_done <= 1'b0;
    end else if (press_start) begin
      pressing <= 1'b1;
      lp_cnt <= '0;
    end else if (pressing && !lp_done) begin
      lp_cnt <= lp_cnt + 1'b1;
      if (lp_cnt + 1'b1 == lp_len) lp_done <= 1'b1;
    end
  end
  wire lp_expire = pressing && !lp_done && (lp_cnt + 1'b1 == lp_len) && btn_low;
  wire warn_hit = pressing && !lp_done && (lp_cnt + 1'b1 == lp_len - CNT_W'(WARN_LEAD_CYCLES));

  // Input power must hold for the whole press when required
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) vin_ok_press <= 1'b1;
    else if (press_start) vin_ok_press <= input_power_valid_in;
    else if (pressing && !input_power_valid_in) vin_ok_press <= 1'b0;
  end
  wire reset_qualified = !reset_requires_input_power_in || (vin_ok_press && input_power_valid_in);

  wire lp_reset = lp_expire && (press_action == ACT_HARDWARE_RESET_REQUEST) && reset_qualified;
  wire lp_ship = lp_expire && press_action[ACT_SHIP_BIT];

  // Adapter watchdog, armed only by host enable after a valid adapter
  logic [CNT_W-1:0] wd_cnt;
  logic wd_run;
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      wd_run <= 1'b0;
      wd_cnt <= '0;
    end else if (!adapter_watchdog_enable_in || !adapter_connect_in || i2c_transaction_in) begin
      wd_run <= adapter_watchdog_enable_in && adapter_connect_in && !i2c_transaction_in ? 1'b1 : 1'b0;
      wd_cnt <= '0;
    end else if (!wd_run) begin
      wd_run <= 1'b1;
      wd_cnt <= '0;
    end else if (wd_cnt != CNT_W'(WDOG_CYCLES)) begin
      wd_cnt <= wd_cnt + 1'b1;
    end
  end
  // A completed transaction stops the watchdog until a fresh adapter connect
  logic wd_served, adapter_q;
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      wd_served <= 1'b0;
      adapter_q <= 1'b0;
    end else begin
      adapter_q <= adapter_connect_in;
      if (adapter_connect_in && !adapter_q) wd_served <= 1'b0;
      else if (i2c_transaction_in) wd_served <= 1'b1;
    end
  end
  // Enable and adapter gate the fire directly, since wd_run lags them by one cycle
  wire wd_fire = adapter_watchdog_enable_in && adapter_connect_in && wd_run && !wd_served &&
    (wd_cnt + 1'b1 == CNT_W'(WDOG_CYCLES));

  // Power cycle sequencer
  logic [CNT_W-1:0] off_cnt;
  wire start_reset = lp_reset || hardware_reset_request_in || wd_fire;
  always_comb begin
    next_pwr = pwr;
    unique case (pwr)
      BRW_RUN: begin
        if (start_reset) next_pwr = BRW_OFF;
        else if (lp_ship) next_pwr = BRW_SHIP;
      end
      BRW_OFF: if (off_cnt + 1'b1 == CNT_W'(PCYC_OFF_CYCLES)) next_pwr = BRW_RUN;
      BRW_SHIP: next_pwr = BRW_SHIP;
    endcase
  end
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      pwr <= BRW_RUN;
      off_cnt <= '0;
    end else begin
      pwr <= next_pwr;
      off_cnt <= (pwr == BRW_OFF) ? off_cnt + 1'b1 : '0;
    end
  end
  assign system_output_rail_en_out = (pwr == BRW_RUN);
  assign digital_io_rail_en_out = (pwr != BRW_SHIP);
  assign ship_mode_out = (pwr == BRW_SHIP);
  assign hardware_reset_request_active_out = (pwr == BRW_OFF);

  // Sticky warning flag; set wins over a host read
  logic warn_flag, cv_flag;
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) warn_flag <= 1'b0;
    else if (warn_hit) warn_flag <= 1'b1;
    else if (flags_read_in) warn_flag <= 1'b0;
  end
  assign reset_warning_flag_out = warn_flag;
  // Status follows regulation; charging and timer are untouched here
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) cv_flag <= 1'b0;
    else cv_flag <= cv_regulation_in;
  end
  assign cv_status_flag_out = cv_flag;

  // Start-up qualification
  logic ints_ok;
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) ints_ok <= 1'b0;
    else if (startup_fault_in && !ints_ok) ints_ok <= 1'b0;
    else if (startup_valid_in) ints_ok <= 1'b1;
  end

  // Warning interrupt rides the flag's rising edge, so an uncleared flag stays silent
  wire [NUM_SRC-1:0] src_cond;
  assign src_cond[SRC_RESET_WARN] = warn_flag;
  assign src_cond[SRC_CV] = cv_flag;
  assign src_cond[SRC_CHG_DONE] = charge_done_in;
  assign src_cond[SRC_FAULT] = fault_in;
  assign src_cond[SRC_STATUS] = status_change_in;
  wire [NUM_SRC-1:0] src_evt;
  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++) begin : g_src
      brw_edge_irq u_src (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .cond_in(src_cond[g]),
        .mask_in(int_mask_in[g]),
        .event_out(src_evt[g])
      );
    end
  endgenerate
  wire any_evt = (|src_evt) && ints_ok;
  logic drive_low;
  brw_pulse_gen #(.WIDTH_CYC(INT_CYCLES)) u_pulse (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .trig_in(any_evt),
    .drive_low_out(drive_low)
  );
  assign int_n_out = 1'b0;
  assign int_oe_out = drive_low;

  property p_wd_off_reset;
    @(posedge sys_clk_in) disable iff (rst_in)
      !adapter_watchdog_enable_in |-> !wd_fire;
  endproperty
  a_wd_off_reset: assert property (p_wd_off_reset) else $error("watchdog fired while disabled");
  property p_reset_cycle;
    @(posedge sys_clk_in) disable iff (rst_in)
      (pwr == BRW_RUN && start_reset) |=> hardware_reset_request_active_out && !system_output_rail_en_out;
  endproperty
  a_reset_cycle: assert property (p_reset_cycle) else $error("reset did not start power cycle");
  property p_vdd_on;
    @(posedge sys_clk_in) disable iff (rst_in)
      hardware_reset_request_active_out |-> digital_io_rail_en_out;
  endproperty
  a_vdd_on: assert property (p_vdd_on) else $error("io rail dropped during reset");
  property p_no_int_unqual;
    @(posedge sys_clk_in) disable iff (rst_in)
      (!ints_ok && !int_oe_out) |=> !int_oe_out;
  endproperty
  a_no_int_unqual: assert property (p_no_int_unqual) else $error("interrupt before start-up");
  property p_mask;
    @(posedge sys_clk_in) disable iff (rst_in)
      (&int_mask_in && !int_oe_out) |=> !int_oe_out;
  endproperty
  a_mask: assert property (p_mask) else $error("masked interrupt pulsed");
  property p_warn_flag;
    @(posedge sys_clk_in) disable iff (rst_in)
      warn_hit |=> reset_warning_flag_out;
  endproperty
  a_warn_flag: assert property (p_warn_flag) else $error("warning flag not set");
  property p_release;
    @(posedge sys_clk_in) disable iff (rst_in)
      !btn_low |=> !pressing;
  endproperty
  a_release: assert property (p_release) else $error("press survived release");
  property p_block;
    @(posedge sys_clk_in) disable iff (rst_in)
      (long_press_action_wr_in && wr_block) |=> $stable(action);
  endproperty
  a_block: assert property (p_block) else $error("blocked action write took effect");
  property p_ship_hold;
    @(posedge sys_clk_in) disable iff (rst_in)
      ship_mode_out |=> ship_mode_out && !system_output_rail_en_out;
  endproperty
  a_ship_hold: assert property (p_ship_hold) else $error("ship mode left without reset");
  sequence s_lp_reset_expiry;
    lp_expire && (press_action == ACT_HARDWARE_RESET_REQUEST) && reset_qualified && (pwr == BRW_RUN);
  endsequence
  property p_lp_reset_now;
    @(posedge sys_clk_in) disable iff (rst_in)
      s_lp_reset_expiry |=> hardware_reset_request_active_out;
  endproperty
  a_lp_reset_now: assert property (p_lp_reset_now) else $error("long-press reset delayed");
endmodule

//--- testbench/brw_host_model.sv
// Host processor and push-button model on the far side of the block
module brw_host_model (
  input wire logic sys_clk_in,
  output logic button_n_out,
  output logic i2c_out,
  output logic flags_read_out,
  output logic [1:0] action_out,
  output logic action_wr_out,
  output logic hw_req_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    button_n_out = 1'b1;
    i2c_out = 1'b0;
    flags_read_out = 1'b0;
    action_out = 2'h1;
    action_wr_out = 1'b0;
    hw_req_out = 1'b0;
  end
  // Released pin reads high through its pull-up
  task automatic press(input int cyc);
    @(negedge sys_clk_in) button_n_out = 1'b0;
    repeat (cyc) @(negedge sys_clk_in);
    button_n_out = 1'b1;
  endtask
  // One-cycle pulse: 0 bus transaction, 1 flag read, 2 reset request
  task automatic pulse(input int which);
    @(negedge sys_clk_in);
    i2c_out = (which == 0);
    flags_read_out = (which == 1);
    hw_req_out = (which == 2);
    @(negedge sys_clk_in);
    {i2c_out, flags_read_out, hw_req_out} = 3'h0;
  endtask
  task automatic write_action(input logic [1:0] act);
    @(negedge sys_clk_in) action_out = act;
    action_wr_out = 1'b1;
    @(negedge sys_clk_in) action_wr_out = 1'b0;
  endtask
endmodule

//--- testbench/test_brw_top.sv
// Self-checking bench for the button reset, watchdog and interrupt block
module test_brw_top;
  timeunit 1ns;
  timeprecision 1ns;
  import brw_pkg::*;
  localparam int LP = 100;
  localparam int WD = 200;
  localparam int IC = 16;
  logic sys_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic pwr_req = 1'b0, pwr_ok = 1'b0, adapter = 1'b0, wd_en = 1'b0, boot_ok = 1'b0, boot_fault = 1'b1;
  logic [31:0] lp_len_in = 32'h0;
  logic [3:0] src = 4'h0;
  logic [4:0] mask = 5'h00;
  logic btn_n, i2c, rd, wr, hreq, warn, cvf, srail, iorail, ship, hwact, int_n, int_oe;
  logic [1:0] act, act_q;
  logic oe_q, hw_q, ship_q;
  int width, mismatches, compares;
  int q[$];
  always #5 sys_clk_in = ~sys_clk_in;
  brw_host_model m (.sys_clk_in(sys_clk_in), .button_n_out(btn_n), .i2c_out(i2c), .flags_read_out(rd),
    .action_out(act), .action_wr_out(wr), .hw_req_out(hreq));
  brw_top #(.WDOG_CYCLES(WD), .LPRESS_CYCLES_DEF(LP), .WARN_LEAD_CYCLES(20), .PCYC_OFF_CYCLES(10),
    .INT_CYCLES(IC)) dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .button_input_n_in(btn_n),
    .long_press_action_in(act), .long_press_action_wr_in(wr), .long_press_cycles_in(lp_len_in),
    .reset_requires_input_power_in(pwr_req), .input_power_valid_in(pwr_ok), .adapter_connect_in(adapter),
    .hardware_reset_request_in(hreq), .adapter_watchdog_enable_in(wd_en), .i2c_transaction_in(i2c),
    .startup_valid_in(boot_ok), .startup_fault_in(boot_fault), .cv_regulation_in(src[0]), .charge_done_in(src[1]),
    .fault_in(src[2]), .status_change_in(src[3]), .int_mask_in(mask), .flags_read_in(rd),
    .reset_warning_flag_out(warn), .cv_status_flag_out(cvf), .long_press_action_out(act_q),
    .system_output_rail_en_out(srail), .digital_io_rail_en_out(iorail), .ship_mode_out(ship),
    .hardware_reset_request_active_out(hwact), .int_n_out(int_n), .int_oe_out(int_oe));
  task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (e !== g) begin
      mismatches++;
      $display("unexpected %s: expected %0h seen %0h", n, e, g);
    end
  endtask
  task automatic final_report();
    if (mismatches == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Event codes: 1 interrupt pulse, 2 power cycle, 3 ship entry
  task automatic take(input int code);
    if (q.size() == 0) check("unexpected event", 0, code);
    else check("event", q.pop_front(), code);
  endtask
  always @(negedge sys_clk_in) begin
    if (rst_in) begin
      width = 0;
    end else begin
      if (int_oe && !oe_q) take(1);
      if (int_oe) width++;
      if (int_oe) check("int level", 0, int_n);
      if (!int_oe && oe_q) begin
        check("pulse width", IC, width);
        width = 0;
      end
      if (hwact && !hw_q) take(2);
      if (ship && !ship_q) take(3);
      if (hwact) check("io rail", 1, iorail);
    end
    {oe_q, hw_q, ship_q} = {int_oe, hwact, ship};
  end
  task automatic drain(input int bound);
    int n;
    n = 0;
    while (q.size() != 0 && n < bound) begin
      @(negedge sys_clk_in);
      n++;
    end
    if (q.size() != 0) begin
      check("pending events", 0, q.size());
      final_report();
    end
    repeat (IC + 30) @(negedge sys_clk_in);
  endtask
  // Long press: warning pulse first, then the expected action if any
  task automatic lp(input int ev);
    q.push_back(1);
    if (ev != 0) q.push_back(ev);
    m.press(LP + 30);
    drain(400);
    if (ev == 0) check("warn flag", 1, warn);
    m.pulse(1);
    @(negedge sys_clk_in) check("warn cleared", 0, warn);
  endtask
  initial begin
    int r;
    r = $urandom(23);
    repeat (8) @(posedge sys_clk_in);
    @(negedge sys_clk_in) rst_in = 1'b0;
    check("rest state", {1'b1, 1'b1, 1'b0, 1'b0, ACT_NONE}, {srail, iorail, ship, int_oe, act_q});
    {src[1], boot_ok} = 2'h3;
    repeat (40) @(negedge sys_clk_in);
    src[1] = 1'b0;
    boot_fault = 1'b0;
    for (int i = 0; i < 4; i++) begin
      @(negedge sys_clk_in) mask = 5'h1F;
      src[i] = 1'b1;
      repeat (5 + $urandom % 20) @(negedge sys_clk_in);
      if (i == 0) check("cv flag", 1, cvf);
      mask[i+1] = 1'b0;
      repeat (40) @(negedge sys_clk_in);
      src[i] = 1'b0;
      repeat (4) @(negedge sys_clk_in);
      q.push_back(1);
      src[i] = 1'b1;
      drain(50);
      src[i] = 1'b0;
    end
    mask = 5'h00;
    lp(0);
    fork
      lp(0);
      begin
        repeat (40) @(negedge sys_clk_in);
        m.write_action(ACT_HARDWARE_RESET_REQUEST);
      end
    join
    check("action kept", ACT_NONE, act_q);
    m.write_action(ACT_HARDWARE_RESET_REQUEST);
    @(negedge sys_clk_in) check("action", ACT_HARDWARE_RESET_REQUEST, act_q);
    pwr_req = 1'b1;
    lp(0);
    pwr_ok = 1'b1;
    m.press(LP / 2);
    repeat (LP) @(negedge sys_clk_in);
    fork
      lp(2);
      begin
        repeat (40) @(negedge sys_clk_in);
        lp_len_in = 32'(LP / 2);
      end
    join
    lp_len_in = 32'(LP);
    check("rail back", 1, srail);
    q.push_back(2);
    m.pulse(2);
    drain(50);
    adapter = 1'b1;
    repeat (WD + 50) @(negedge sys_clk_in);
    {adapter, wd_en} = 2'h1;
    @(negedge sys_clk_in) adapter = 1'b1;
    q.push_back(2);
    drain(WD + 50);
    adapter = 1'b0;
    @(negedge sys_clk_in) adapter = 1'b1;
    repeat (WD / 2) @(negedge sys_clk_in);
    m.pulse(0);
    repeat (WD * 2) @(negedge sys_clk_in);
    {adapter, wd_en} = 2'h0;
    m.write_action(2'h2 | 2'($urandom % 2));
    lp(3);
    final_report();
  end
endmodule
